// >>> src/add_parallel_store_datapath.v
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "add_par_defines.vh"
module add_parallel_store_datapath #(
  parameter AW          = 8,
  parameter REG_SRC2_OK = 1
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_EXEC  = 2'd2;

  // Memory word to extended float: low fraction bits zero
  function [39:0] mem_to_ext;
    input [31:0] w;
    begin
      mem_to_ext = {w, 8'h00};
    end
  endfunction

  // Indirect address: auxiliary register plus displacement or index
  function [AW-1:0] ind_addr;
    input [12:0] d;
    input [31:0] arv;
    input [31:0] idx0v;
    input [31:0] idx1v;
    input        tmode;
    reg   [31:0] off;
    begin
      case (d[`D_OSEL])
        `OSEL_IDX0: off = idx0v;
        `OSEL_IDX1: off = idx1v;
        default:    off = tmode ? {31'h0, d[3]} : {24'h0, d[`D_DISP]};
      endcase
      ind_addr = arv[AW-1:0] + off[AW-1:0];
    end
  endfunction

  reg  [39:0]   rf [0:17];
  reg  [1:0]    state;
  reg           sat_mode;
  reg  [6:0]    flags;
  reg  [2:0]    ir_op;
  reg  [1:0]    ir_mode;
  reg  [4:0]    ir_dst;
  reg  [4:0]    ir_s1;
  reg  [4:0]    ir_s2;
  reg  [4:0]    ir_s3;
  reg  [12:0]   ind_a;
  reg  [12:0]   ind_b;
  reg  [31:0]   imm;
  reg  [4:0]    reg_sel;
  reg  [AW-1:0] mem_addr;
  reg  [3:0]    irq_stat;
  reg  [3:0]    irq_en;
  reg  [39:0]   reg_x;
  reg  [39:0]   reg_y;
  reg  [39:0]   st_val;
  reg  [AW-1:0] st_addr;
  reg  [31:0]   rdata;
  reg           rerr;
  reg  [39:0]   xf;
  reg  [39:0]   yf;
  reg  [31:0]   xi;
  reg  [31:0]   yi;
  reg  [AW-1:0] addr_a;
  reg  [AW-1:0] addr_b;
  reg  [AW-1:0] ma_addr;
  reg           m_we;
  reg  [AW-1:0] m_wa;
  reg  [31:0]   m_wd;
  reg signed [9:0]  fea;
  reg signed [9:0]  feb;
  reg signed [9:0]  fe;
  reg signed [33:0] fma;
  reg signed [33:0] fmb;
  reg signed [33:0] fsum;
  reg signed [33:0] ft;
  reg  [9:0]    fdiff;
  reg  [5:0]    fsh;
  reg  [32:0]   fm;
  reg           ffound;
  reg           f_ovf;
  reg           f_unf;
  reg  [39:0]   fres;
  reg  [32:0]   isum;
  reg           iovf;
  reg  [31:0]   ires;
  reg  [6:0]    next_flags;
  reg  [3:0]    ev;
  integer       i;
  integer       k;

  wire [31:0]   ra_data;
  wire [31:0]   rb_data;
  wire          acc     = psel & penable & pready;
  wire          wr      = acc & pwrite;
  wire          busy    = (state != ST_IDLE);
  wire          is_fp   = (ir_op == `OP_FADD2) | (ir_op == `OP_FADD3) | (ir_op == `OP_FADD_ST);
  wire          g_form  = (ir_op == `OP_FADD2) | (ir_op == `OP_IADD2);
  wire          p_regs2 = (REG_SRC2_OK != 0) & ir_mode[0];
  wire          start   = wr & (paddr == `A_INSTR) & ~busy;
  wire          bad_op  = start & (pwdata[`F_OP] > `OP_IADD3);
  wire [4:0]    wdst    = is_fp ? {2'b00, ir_dst[2:0]} : ir_dst;
  wire          exec    = (state == ST_EXEC);

  // Operand addresses for both memory read ports
  always @* begin
    addr_a = ind_addr(ind_a, rf[{2'b01, ind_a[`D_AR]}][31:0], rf[`RI_IDX0][31:0],
                      rf[`RI_IDX1][31:0], ~g_form);
    if (g_form && ir_mode == `G_DIR) begin
      addr_a = imm[AW-1:0];
    end
    addr_b = ind_addr(ind_b, rf[{2'b01, ind_b[`D_AR]}][31:0], rf[`RI_IDX0][31:0],
                      rf[`RI_IDX1][31:0], 1'b1);
    ma_addr = (state == ST_FETCH) ? addr_a : mem_addr;
  end

  // Store of the parallel form wins the write port during execute
  always @* begin
    m_we = 1'b0;
    m_wa = mem_addr;
    m_wd = pwdata;
    if (exec && ir_op == `OP_FADD_ST) begin
      m_we = 1'b1;
      m_wa = st_addr;
      m_wd = st_val[39:8];
    end else if (wr && paddr == `A_MEM_DATA && !busy) begin
      m_we = 1'b1;
    end
  end

  operand_memory #(
    .AW (AW),
    .DW (32)
  ) operand_memory_i (
    .clk     (clk),
    .ra_addr (ma_addr),
    .ra_data (ra_data),
    .rb_addr (addr_b),
    .rb_data (rb_data),
    .we      (m_we),
    .wa      (m_wa),
    .wd      (m_wd)
  );

  // Operand selection by form and addressing field
  always @* begin
    xf = reg_x;
    xi = reg_x[31:0];
    yf = reg_y;
    yi = reg_y[31:0];
    if (g_form) begin
      case (ir_mode)
        `G_REG: begin
          yf = reg_y;
          yi = reg_y[31:0];
        end
        `G_IMM: begin
          yf = mem_to_ext(imm);
          yi = imm;
        end
        default: begin
          yf = mem_to_ext(ra_data);
          yi = ra_data;
        end
      endcase
    end else if (ir_op == `OP_FADD_ST) begin
      if (!p_regs2) begin
        yf = mem_to_ext(ra_data);
      end
    end else begin
      if (ir_mode[0]) begin
        xf = mem_to_ext(ra_data);
        xi = ra_data;
      end
      if (ir_mode[1]) begin
        yf = mem_to_ext(rb_data);
        yi = rb_data;
      end
    end
  end

  // Float add: align, sum, normalise, range check
  always @* begin
    fea = {{2{xf[39]}}, xf[39:32]};
    feb = {{2{yf[39]}}, yf[39:32]};
    fma = (xf[39:32] == `FP_ZERO_EXP) ? 34'sd0 : {xf[31], xf[31], ~xf[31], xf[30:0]};
    fmb = (yf[39:32] == `FP_ZERO_EXP) ? 34'sd0 : {yf[31], yf[31], ~yf[31], yf[30:0]};
    if (fea >= feb) begin
      fdiff = fea - feb;
      fe    = fea;
    end else begin
      fdiff = feb - fea;
      fe    = feb;
    end
    fsh = (fdiff > 10'd33) ? 6'd34 : fdiff[5:0];
    if (fea >= feb) begin
      fmb = fmb >>> fsh;
    end else begin
      fma = fma >>> fsh;
    end
    fsum = fma + fmb;
    if (fsum[33] ^ fsum[32]) begin
      ft = fsum >>> 1;
      fe = fe + 10'sd1;
    end else begin
      ft = fsum;
    end
    fm     = ft[32:0];
    fsh    = 6'd0;
    ffound = 1'b0;
    for (i = 31; i >= 0; i = i - 1) begin
      if (!ffound && (fm[i] != fm[32])) begin
        fsh    = 6'd31 - i[5:0];
        ffound = 1'b1;
      end
    end
    fm    = fm << fsh;
    fe    = fe - {4'd0, fsh};
    f_ovf = ffound && (fe > 10'sd127);
    f_unf = ffound && (fe < -10'sd127);
    if (!ffound || f_unf) begin
      fres = {`FP_ZERO_EXP, 32'h0};
    end else if (f_ovf) begin
      fres = {8'h7f, fm[32], {31{~fm[32]}}};
    end else begin
      fres = {fe[7:0], fm[32], fm[30:0]};
    end
  end

  // Signed integer add with carry, overflow and saturation
  always @* begin
    isum = {1'b0, xi} + {1'b0, yi};
    iovf = (xi[31] == yi[31]) && (isum[31] != xi[31]);
    ires = isum[31:0];
    if (sat_mode && iovf) begin
      ires = xi[31] ? 32'h80000000 : 32'h7fffffff;
    end
  end

  // Flag update for the executing instruction
  always @* begin
    next_flags = flags;
    ev = 4'h0;
    ev[`EV_BAD] = bad_op;
    if (exec) begin
      ev[`EV_DONE] = 1'b1;
      ev[`EV_OVF]  = is_fp ? f_ovf : iovf;
      ev[`EV_UNF]  = is_fp & f_unf;
      if (wdst < 5'd8) begin
        if (is_fp) begin
          next_flags[`FL_UNL] = flags[`FL_UNL] | f_unf;
          next_flags[`FL_OVL] = flags[`FL_OVL] | f_ovf;
          next_flags[`FL_UNF] = f_unf;
          next_flags[`FL_V]   = f_ovf;
          next_flags[`FL_N]   = fres[31];
          next_flags[`FL_Z]   = (fres[39:32] == `FP_ZERO_EXP);
        end else begin
          next_flags[`FL_OVL] = flags[`FL_OVL] | iovf;
          next_flags[`FL_UNF] = 1'b0;
          next_flags[`FL_V]  = iovf;
          next_flags[`FL_C]  = isum[32];
          next_flags[`FL_N]  = ires[31];
          next_flags[`FL_Z]  = (ires == 32'h0);
        end
      end
    end
  end

  // Sequencer: fetch samples sources, execute writes results
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start && !bad_op) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: state <= ST_EXEC;
        ST_EXEC:  state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // Sources latched at the start of execute
  always @(posedge clk) begin
    if (rst) begin
      reg_x   <= 40'h0;
      reg_y   <= 40'h0;
      st_val  <= 40'h0;
      st_addr <= {AW{1'b0}};
    end else if (state == ST_FETCH) begin
      reg_x   <= g_form ? rf[ir_dst] : rf[{2'b00, ir_s1[2:0]}];
      reg_y   <= rf[ir_s2 > `RI_LAST ? 5'd0 : ir_s2];
      st_val  <= rf[{2'b00, ir_s3[2:0]}];
      st_addr <= addr_b;
      if (g_form) begin
        reg_y <= rf[ir_s1 > `RI_LAST ? 5'd0 : ir_s1];
      end
      if (!g_form && ir_op != `OP_FADD_ST) begin
        reg_x <= rf[ir_s1 > `RI_LAST ? 5'd0 : ir_s1];
      end
    end
  end

  // Register file: result at end of execute, else software access
  always @(posedge clk) begin
    if (rst) begin
      for (k = 0; k <= 17; k = k + 1) begin
        rf[k] <= 40'h0;
      end
    end else if (exec) begin
      if (wdst <= `RI_LAST) begin
        rf[wdst] <= is_fp ? fres : {rf[wdst][39:32], ires};
      end
    end else if (wr && !busy && reg_sel <= `RI_LAST) begin
      if (paddr == `A_REG_LO) begin
        rf[reg_sel][31:0] <= pwdata;
      end
      if (paddr == `A_REG_EXP) begin
        rf[reg_sel][39:32] <= pwdata[7:0];
      end
    end
  end

  // Software registers, flags and interrupt status
  always @(posedge clk) begin
    if (rst) begin
      sat_mode <= `CTRL_RST;
      flags    <= `FLAGS_RST;
      ir_op    <= 3'd0;
      ir_mode  <= 2'd0;
      ir_dst   <= 5'd0;
      ir_s1    <= 5'd0;
      ir_s2    <= 5'd0;
      ir_s3    <= 5'd0;
      ind_a    <= 13'h0;
      ind_b    <= 13'h0;
      imm      <= 32'h0;
      reg_sel  <= 5'd0;
      mem_addr <= {AW{1'b0}};
      irq_stat <= 4'h0;
      irq_en   <= 4'h0;
      irq      <= 1'b0;
    end else begin
      if (exec) begin
        flags <= next_flags;
      end else if (wr && paddr == `A_FLAGS) begin
        flags <= pwdata[6:0];
      end
      if (wr && !busy) begin
        case (paddr)
          `A_CTRL:     sat_mode <= pwdata[0];
          `A_IND_A:    ind_a    <= pwdata[12:0];
          `A_IND_B:    ind_b    <= pwdata[12:0];
          `A_IMM:      imm      <= pwdata;
          `A_REG_SEL:  reg_sel  <= pwdata[4:0];
          `A_MEM_ADDR: mem_addr <= pwdata[AW-1:0];
          `A_IRQ_EN:   irq_en   <= pwdata[3:0];
          default: ;
        endcase
      end
      if (start) begin
        ir_op   <= pwdata[`F_OP];
        ir_mode <= pwdata[`F_MODE];
        ir_dst  <= pwdata[`F_DST];
        ir_s1   <= pwdata[`F_S1];
        ir_s2   <= pwdata[`F_S2];
        ir_s3   <= pwdata[`F_S3];
      end
      if (wr && paddr == `A_IRQ_CLR) begin
        irq_stat <= (irq_stat & ~pwdata[3:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // Read-back decode
  always @* begin
    rdata = 32'h0;
    rerr  = 1'b0;
    case (paddr)
      `A_CTRL:     rdata = {31'h0, sat_mode};
      `A_INSTR:    rdata = {7'h0, ir_s3, ir_s2, ir_s1, ir_dst, ir_mode, ir_op};
      `A_IND_A:    rdata = {19'h0, ind_a};
      `A_IND_B:    rdata = {19'h0, ind_b};
      `A_IMM:      rdata = imm;
      `A_FLAGS:    rdata = {25'h0, flags};
      `A_REG_SEL:  rdata = {27'h0, reg_sel};
      `A_REG_LO:   rdata = (reg_sel <= `RI_LAST) ? rf[reg_sel][31:0] : 32'h0;
      `A_REG_EXP:  rdata = (reg_sel <= `RI_LAST) ? {24'h0, rf[reg_sel][39:32]} : 32'h0;
      `A_MEM_ADDR: rdata = {{(32-AW){1'b0}}, mem_addr};
      `A_MEM_DATA: rdata = ra_data;
      `A_IRQ_STAT: rdata = {28'h0, irq_stat};
      `A_IRQ_CLR:  rdata = 32'h0;
      `A_IRQ_EN:   rdata = {28'h0, irq_en};
      default:     rerr  = 1'b1;
    endcase
  end

  // APB answer: one wait state, registered data
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0 : rdata;
        pslverr <= rerr;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // add_parallel_store_datapath

// >>> src/add_par_defines.vh
`ifndef ADD_PAR_DEFINES_VH
`define ADD_PAR_DEFINES_VH

// Register byte offsets
`define A_CTRL      8'h00
`define A_INSTR     8'h04
`define A_IND_A     8'h08
`define A_IND_B     8'h0c
`define A_IMM       8'h10
`define A_FLAGS     8'h14
`define A_REG_SEL   8'h18
`define A_REG_LO    8'h1c
`define A_REG_EXP   8'h20
`define A_MEM_ADDR  8'h24
`define A_MEM_DATA  8'h28
`define A_IRQ_STAT  8'h2c
`define A_IRQ_CLR   8'h30
`define A_IRQ_EN    8'h34

// Instruction word fields
`define F_OP    2:0
`define F_MODE  4:3
`define F_DST   9:5
`define F_S1    14:10
`define F_S2    19:15
`define F_S3    24:20

// Operation codes
`define OP_FADD2   3'd0
`define OP_FADD3   3'd1
`define OP_FADD_ST 3'd2
`define OP_IADD2   3'd3
`define OP_IADD3   3'd4

// General addressing field
`define G_REG 2'b00
`define G_DIR 2'b01
`define G_IND 2'b10
`define G_IMM 2'b11

// Indirect descriptor fields and offset selects
`define D_AR        2:0
`define D_DISP      10:3
`define D_OSEL      12:11
`define OSEL_DISP   2'd0
`define OSEL_IDX0   2'd1
`define OSEL_IDX1   2'd2

// Register numbers
`define RI_IDX0 5'd16
`define RI_IDX1 5'd17
`define RI_LAST 5'd17

// Flag bit positions
`define FL_C   0
`define FL_V   1
`define FL_Z   2
`define FL_N   3
`define FL_UNF 4
`define FL_OVL 5
`define FL_UNL 6

// Interrupt event bit positions
`define EV_DONE 0
`define EV_OVF  1
`define EV_UNF  2
`define EV_BAD  3

// Reset values and constants
`define CTRL_RST    1'b0
`define FLAGS_RST   7'h00
`define FP_ZERO_EXP 8'h80
`define EXEC_CYCLES 1

`endif

// >>> src/operand_memory.v
`timescale 1ns/1ps

module operand_memory #(
  parameter AW = 8,
  parameter DW = 32
) (
  input  wire          clk,
  input  wire [AW-1:0] ra_addr,
  output reg  [DW-1:0] ra_data,
  input  wire [AW-1:0] rb_addr,
  output reg  [DW-1:0] rb_data,
  input  wire          we,
  input  wire [AW-1:0] wa,
  input  wire [DW-1:0] wd
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Registered reads see the old word on a same-address write
  always @(posedge clk) begin
    ra_data <= mem[ra_addr];
    rb_data <= mem[rb_addr];
    if (we) begin
      mem[wa] <= wd;
    end
  end

endmodule // operand_memory

// >>> test/add_par_checker_assertions.sv
`timescale 1ns/1ps
`include "add_par_defines.vh"
module add_par_checker (
  input wire        clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus events
  sequence s_first;
    psel && penable && !$past(penable);
  endsequence
  sequence s_clr_all;
    psel && penable && pready && pwrite && paddr == `A_IRQ_CLR && pwdata == 32'h0000000f;
  endsequence
  property p_ready_wait;
    s_first |-> !pready ##1 pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h00000000;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("prdata not zero on write");
  property p_reset_quiet;
    $fell(rst) |-> !irq && !pready && !pslverr;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_unmapped;
    pready && paddr > `A_IRQ_EN |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
  property p_mapped;
    pready && paddr <= `A_IRQ_EN && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error on mapped address");
  property p_irq_clear;
    s_clr_all |=> ##1 !irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq stays after clear");
endmodule // add_par_checker
bind add_parallel_store_datapath add_par_checker add_par_checker_i (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// >>> test/apb_master.sv
`timescale 1ns/1ps
module apb_master (
  input  wire        clk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Setup, access, hold until pready sampled high
  task xfer(input dir, input [7:0] a, input [31:0] wd, output [31:0] rd, output err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= dir;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // apb_master

// >>> test/add_parallel_store_datapath_bench.sv
`timescale 1ns/1ps
`include "add_par_defines.vh"
module add_parallel_store_datapath_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  wire        psel, penable, pwrite, pready, pslverr, irq;
  wire [7:0]  paddr;
  wire [31:0] pwdata, prdata;
  reg  [31:0] d;
  reg         e;
  integer     fail_count = 0;
  integer     compares = 0;
  integer     cycles = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  apb_master apb_master_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  add_parallel_store_datapath add_parallel_store_datapath_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  task tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      fail_count = fail_count + 1;
      $display("ERROR t=%0t timeout", $time);
      tally_and_finish;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    apb_master_i.xfer(1'b1, a, v, d, e);
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    apb_master_i.xfer(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask
  task set_reg(input [4:0] n, input [39:0] v);
    wr(`A_REG_SEL, {27'h0, n});
    wr(`A_REG_LO, v[31:0]);
    wr(`A_REG_EXP, {24'h0, v[39:32]});
  endtask
  task reg_chk(input [4:0] n, input [39:0] v);
    wr(`A_REG_SEL, {27'h0, n});
    rchk(`A_REG_LO, v[31:0]);
    rchk(`A_REG_EXP, {24'h0, v[39:32]});
  endtask
  task mem_w(input [31:0] a, input [31:0] v);
    wr(`A_MEM_ADDR, a);
    wr(`A_MEM_DATA, v);
  endtask
  // Issue one instruction, check events, clear them
  task exec(input [2:0] op, input [1:0] m, input [4:0] dst, input [4:0] s1,
            input [4:0] s2, input [4:0] s3, input [31:0] stat);
    wr(`A_INSTR, {7'h0, s3, s2, s1, dst, m, op});
    rchk(`A_IRQ_STAT, stat);
    wr(`A_IRQ_CLR, 32'h0000000f);
  endtask
  task done(input [79:0] name);
    $display("test %s done", name);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(`A_FLAGS, 32'h0);
    rchk(`A_CTRL, 32'h0);
    rchk(`A_IRQ_STAT, 32'h0);
    rchk(8'h3c, 32'h0);
    chk({31'h0, e}, 32'h1);
    done("reset");
    set_reg(5'd1, 40'h05);
    set_reg(5'd2, 40'h07);
    exec(3'd3, `G_REG, 5'd1, 5'd2, 5'd0, 5'd0, 32'h1);
    reg_chk(5'd1, 40'h0c);
    rchk(`A_FLAGS, 32'h0);
    set_reg(5'd3, 40'hffffffcb);
    set_reg(5'd7, 40'h35);
    exec(3'd3, `G_REG, 5'd7, 5'd3, 5'd0, 5'd0, 32'h1);
    reg_chk(5'd7, 40'h0);
    rchk(`A_FLAGS, 32'h05);
    done("int_add");
    wr(`A_FLAGS, 32'h50);
    set_reg(5'd1, 40'h7fffffff);
    wr(`A_IMM, 32'h1);
    exec(3'd3, `G_IMM, 5'd1, 5'd0, 5'd0, 5'd0, 32'h3);
    chk({31'h0, irq}, 32'h0);
    reg_chk(5'd1, 40'h80000000);
    rchk(`A_FLAGS, 32'h6a);
    wr(`A_CTRL, 32'h1);
    set_reg(5'd1, 40'h7fffffff);
    exec(3'd3, `G_IMM, 5'd1, 5'd0, 5'd0, 5'd0, 32'h3);
    reg_chk(5'd1, 40'h7fffffff);
    rchk(`A_FLAGS, 32'h62);
    wr(`A_CTRL, 32'h0);
    done("int_ovf");
    wr(`A_FLAGS, 32'h15);
    set_reg(5'd8, 40'h10);
    exec(3'd3, `G_REG, 5'd8, 5'd2, 5'd0, 5'd0, 32'h1);
    rchk(`A_FLAGS, 32'h15);
    done("ar_dst");
    set_reg(5'd9, 40'h0);
    set_reg(5'd16, 40'h10);
    mem_w(32'h40, 32'h64);
    mem_w(32'hff, 32'h2);
    mem_w(32'h10, 32'h3);
    set_reg(5'd4, 40'h1);
    wr(`A_IMM, 32'h40);
    exec(3'd3, `G_DIR, 5'd4, 5'd0, 5'd0, 5'd0, 32'h1);
    wr(`A_IND_A, 32'h7f9);
    exec(3'd3, `G_IND, 5'd4, 5'd0, 5'd0, 5'd0, 32'h1);
    wr(`A_IND_A, 32'h801);
    exec(3'd3, `G_IND, 5'd4, 5'd0, 5'd0, 5'd0, 32'h1);
    reg_chk(5'd4, 40'h6a);
    done("modes");
    mem_w(32'h1, 32'h20);
    mem_w(32'h0, 32'h5);
    set_reg(5'd5, 40'h10);
    wr(`A_IND_B, 32'h009);
    exec(3'd4, 2'b10, 5'd6, 5'd5, 5'd0, 5'd0, 32'h1);
    reg_chk(5'd6, 40'h30);
    wr(`A_IND_A, 32'h001);
    exec(3'd4, 2'b01, 5'd6, 5'd0, 5'd5, 5'd0, 32'h1);
    reg_chk(5'd6, 40'h15);
    done("three_op");
    set_reg(5'd10, 40'h30);
    mem_w(32'h30, 32'h80000000);
    set_reg(5'd1, 40'h0140000000);
    set_reg(5'd3, 40'h0220000000);
    wr(`A_IND_A, 32'h2);
    wr(`A_IND_B, 32'h2);
    wr(`A_FLAGS, 32'h61);
    exec(3'd2, 2'b00, 5'd3, 5'd1, 5'd0, 5'd3, 32'h1);
    reg_chk(5'd3, 40'h0140000000);
    wr(`A_MEM_ADDR, 32'h30);
    rchk(`A_MEM_DATA, 32'h02200000);
    rchk(`A_FLAGS, 32'h61);
    exec(3'd2, 2'b01, 5'd2, 5'd1, 5'd3, 5'd1, 32'h1);
    reg_chk(5'd2, 40'h0240000000);
    rchk(`A_MEM_DATA, 32'h01400000);
    set_reg(5'd6, 40'h01c0000000);
    exec(3'd1, 2'b00, 5'd5, 5'd1, 5'd6, 5'd0, 32'h1);
    reg_chk(5'd5, 40'h8000000000);
    rchk(`A_FLAGS, 32'h65);
    done("parallel");
    wr(`A_FLAGS, 32'h0);
    set_reg(5'd1, 40'h7f00000000);
    wr(`A_IRQ_EN, 32'h2);
    wr(`A_INSTR, 32'h00000420);
    rchk(`A_IRQ_STAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    rchk(`A_FLAGS, 32'h22);
    wr(`A_IRQ_CLR, 32'h0000000f);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    exec(3'd7, 2'b00, 5'd0, 5'd0, 5'd0, 5'd0, 32'h8);
    done("float_irq");
    tally_and_finish;
  end
endmodule // add_parallel_store_datapath_bench
